// ### core/stream4_cfg_pkg.sv
// Constants and carrier types for the stream-four framing configuration bank.
// Assumes a 32-bit APB register bus and one clock for bus and framing logic.
package stream4_cfg_pkg;
	localparam logic [11:0] ADDR_UNIT_SIZE = 12'h5D0;
	localparam logic [11:0] ADDR_WORDS_PER_LANE = 12'h5DC;
	localparam logic [11:0] ADDR_INTERLACE = 12'h5E0;
	localparam logic [11:0] ADDR_WHOLE_BYTES = 12'h5E4;
	localparam logic [11:0] ADDR_FRACTION_BYTES = 12'h5E8;
	localparam logic [11:0] ADDR_LINE_WAIT = 12'h5EC;
	localparam logic [11:0] ADDR_TABLE_BASE = 12'h800;
	localparam logic [11:0] ADDR_TABLE_LAST = 12'h8FF;
	localparam logic [11:0] ADDR_STATUS = 12'h5F0;
	localparam int INTERLACE_BIT = 0;
	localparam int WHOLE_WIDTH = 8;
	localparam int FRACTION_WIDTH = 10;
	localparam int WAIT_WIDTH = 7;
	localparam int UNIT_WIDTH = 7;
	localparam int WORDS_WIDTH = 16;
	localparam int TABLE_DEPTH = 64;
	localparam logic [6:0] UNIT_SIZE_RESET = 7'h40;
	localparam logic [6:0] UNIT_SIZE_MIN = 7'h20;
	localparam logic [6:0] UNIT_SIZE_MAX = 7'h40;
	localparam logic [9:0] FRACTION_SCALE = 10'h3E8;
	localparam logic [7:0] WHOLE_RESET = 8'h00;
	localparam logic [9:0] FRACTION_RESET = 10'h000;
	localparam logic [6:0] WAIT_RESET = 7'h40;

	typedef struct packed {
		logic interlaced;
		logic [UNIT_WIDTH-1:0] unit_size;
		logic [WHOLE_WIDTH-1:0] whole_bytes;
		logic [FRACTION_WIDTH-1:0] fraction_bytes;
		logic [WAIT_WIDTH-1:0] line_wait;
	} framing_cfg_t;

	typedef enum logic [1:0] {
		FR_IDLE = 2'b00,
		FR_WAIT = 2'b01,
		FR_SEND = 2'b10
	} framing_state_t;
endpackage

// ### core/line_wait_timer.sv
// Counts the programmed initial wait at the start of each line.
// Assumes line_start is a one-cycle pulse from logic on pclk.
`timescale 1ns/1ns
module line_wait_timer (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic line_start,
	input wire logic [stream4_cfg_pkg::WAIT_WIDTH-1:0] wait_cycles,
	// Result
	output logic busy,
	output logic done
);
	import stream4_cfg_pkg::*;

	logic [WAIT_WIDTH-1:0] count;
	logic [WAIT_WIDTH-1:0] next_count;
	logic next_busy;
	logic next_done;

	always_comb begin
		next_count = count;
		next_busy = busy;
		next_done = 1'b0;
		if (line_start) begin
			// A zero wait ends at once so the line is never stalled forever.
			next_count = wait_cycles;
			next_busy = (wait_cycles != '0);
			next_done = (wait_cycles == '0);
		end else if (busy) begin
			next_count = count - 7'h01;
			if (count == 7'h01) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			count <= next_count;
			busy <= next_busy;
			done <= next_done;
		end
	end
endmodule // line_wait_timer

// ### core/unit_byte_pacer.sv
// Gives the valid byte count of each transfer unit from whole and fractional parts.
// Assumes unit_tick is a one-cycle pulse, one per transfer unit.
`timescale 1ns/1ns
module unit_byte_pacer (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic line_start,
	input wire logic unit_tick,
	input wire logic [stream4_cfg_pkg::WHOLE_WIDTH-1:0] whole_bytes,
	input wire logic [stream4_cfg_pkg::FRACTION_WIDTH-1:0] fraction_bytes,
	// Result
	output logic [stream4_cfg_pkg::WHOLE_WIDTH:0] unit_bytes
);
	import stream4_cfg_pkg::*;

	logic [FRACTION_WIDTH:0] acc;
	logic [FRACTION_WIDTH:0] next_acc;
	logic [WHOLE_WIDTH:0] next_unit_bytes;
	logic [FRACTION_WIDTH:0] sum;

	always_comb begin
		sum = acc + {1'b0, fraction_bytes};
		next_acc = acc;
		next_unit_bytes = unit_bytes;
		if (line_start) begin
			next_acc = '0;
			next_unit_bytes = {1'b0, whole_bytes};
		end else if (unit_tick) begin
			// Carry one byte whenever the scaled fraction reaches a whole unit.
			if (sum >= {1'b0, FRACTION_SCALE}) begin
				next_acc = sum - {1'b0, FRACTION_SCALE};
				next_unit_bytes = {1'b0, whole_bytes} + 9'h001;
			end else begin
				next_acc = sum;
				next_unit_bytes = {1'b0, whole_bytes};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= '0;
			unit_bytes <= '0;
		end else begin
			acc <= next_acc;
			unit_bytes <= next_unit_bytes;
		end
	end
endmodule // unit_byte_pacer

// ### core/stream4_tu_framing_config.sv
// APB register bank for the fourth stream's transfer-unit framing setup.
// Assumes an APB master on pclk and framing pulses from logic on the same clock.
//
// How it works
// - Interlace bit 0 set drives the interlace fields of blanking ID and stream attributes.
// - The eight-bit whole field is the minimum valid bytes per unit used by framing.
// - The ten-bit fraction field holds the fractional ratio part scaled by 1000.
// - Each new line waits the seven-bit initial-wait count before data is emitted.
// - Writes at 0x800 to 0x8FF store eight-bit entries into the write-only slot table.
// - Unit size resets to 64, is clamped to 32..64 and its bit 0 stays zero.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module stream4_tu_framing_config (
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Framing events
	input wire logic line_start,
	input wire logic unit_tick,
	input wire logic [5:0] slot_index,
	// Framing outputs
	output stream4_cfg_pkg::framing_cfg_t cfg,
	output logic [stream4_cfg_pkg::WORDS_WIDTH-1:0] words_per_lane,
	output logic vblank_interlace,
	output logic attr_interlace,
	output logic data_enable,
	output logic [stream4_cfg_pkg::WHOLE_WIDTH:0] unit_bytes,
	output logic [7:0] slot_entry
);
	import stream4_cfg_pkg::*;

	// ****************************************************************
	// Register state
	// ****************************************************************
	framing_cfg_t next_cfg;
	logic [WORDS_WIDTH-1:0] next_words_per_lane;
	logic [7:0] slot_table [TABLE_DEPTH];
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic next_vblank_interlace;
	logic next_attr_interlace;
	logic next_data_enable;
	logic [7:0] next_slot_entry;
	framing_state_t state;
	framing_state_t next_state;
	logic wait_busy;
	logic wait_done;
	logic access;
	logic wr;
	logic rd;
	logic table_hit;
	logic [6:0] unit_req;

	assign access = psel && penable && !pready;
	assign wr = access && pwrite;
	assign rd = access && !pwrite;
	assign table_hit = (paddr >= ADDR_TABLE_BASE) && (paddr <= ADDR_TABLE_LAST);

	// ****************************************************************
	// Register writes and reads
	// ****************************************************************
	always_comb begin
		next_cfg = cfg;
		next_words_per_lane = words_per_lane;
		next_prdata = 32'h0000_0000;
		next_pready = access;
		next_pslverr = 1'b0;
		unit_req = pwdata[6:0] & 7'h7E;
		if (wr && pstrb[0]) begin
			if (paddr == ADDR_INTERLACE) begin
				next_cfg.interlaced = pwdata[INTERLACE_BIT];
			end else if (paddr == ADDR_UNIT_SIZE) begin
				// Out-of-range sizes are clamped so framing never sees an unusable unit.
				if (unit_req < UNIT_SIZE_MIN) begin
					next_cfg.unit_size = UNIT_SIZE_MIN;
				end else if (unit_req > UNIT_SIZE_MAX) begin
					next_cfg.unit_size = UNIT_SIZE_MAX;
				end else begin
					next_cfg.unit_size = unit_req;
				end
			end else if (paddr == ADDR_WHOLE_BYTES) begin
				next_cfg.whole_bytes = pwdata[WHOLE_WIDTH-1:0];
			end else if (paddr == ADDR_FRACTION_BYTES && pstrb[1]) begin
				next_cfg.fraction_bytes = pwdata[FRACTION_WIDTH-1:0];
			end else if (paddr == ADDR_LINE_WAIT) begin
				next_cfg.line_wait = pwdata[WAIT_WIDTH-1:0];
			end else if (paddr == ADDR_WORDS_PER_LANE && pstrb[1]) begin
				next_words_per_lane = pwdata[WORDS_WIDTH-1:0];
			end
		end
		if (rd) begin
			if (paddr == ADDR_INTERLACE) begin
				next_prdata = {31'h0000_0000, cfg.interlaced};
			end else if (paddr == ADDR_UNIT_SIZE) begin
				next_prdata = {25'h000_0000, cfg.unit_size};
			end else if (paddr == ADDR_WHOLE_BYTES) begin
				next_prdata = {24'h00_0000, cfg.whole_bytes};
			end else if (paddr == ADDR_FRACTION_BYTES) begin
				next_prdata = {22'h00_0000, cfg.fraction_bytes};
			end else if (paddr == ADDR_LINE_WAIT) begin
				next_prdata = {25'h000_0000, cfg.line_wait};
			end else if (paddr == ADDR_WORDS_PER_LANE) begin
				next_prdata = {16'h0000, words_per_lane};
			end else if (paddr == ADDR_STATUS) begin
				next_prdata = {20'h0_0000, unit_bytes, wait_busy, state};
			end else if (table_hit) begin
				// The slot table is write only; reads return zero without error.
				next_prdata = 32'h0000_0000;
			end else begin
				next_pslverr = 1'b1;
			end
		end else if (wr && !table_hit && paddr != ADDR_INTERLACE && paddr != ADDR_UNIT_SIZE
			&& paddr != ADDR_WHOLE_BYTES && paddr != ADDR_FRACTION_BYTES
			&& paddr != ADDR_LINE_WAIT && paddr != ADDR_WORDS_PER_LANE && paddr != ADDR_STATUS) begin
			next_pslverr = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= '{interlaced: 1'b0, unit_size: UNIT_SIZE_RESET, whole_bytes: WHOLE_RESET,
				fraction_bytes: FRACTION_RESET, line_wait: WAIT_RESET};
			words_per_lane <= '0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			cfg <= next_cfg;
			words_per_lane <= next_words_per_lane;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ****************************************************************
	// Slot table
	// ****************************************************************
	// Every write in the window with pstrb[0] set lands in the entry of its 32-bit word, one per word; the low two address bits are ignored.
	always_ff @(posedge pclk) begin
		if (wr && table_hit && pstrb[0]) begin
			slot_table[paddr[7:2]] <= pwdata[7:0];
		end
	end

	always_comb begin
		next_slot_entry = slot_table[slot_index];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_entry <= 8'h00;
		end else begin
			slot_entry <= next_slot_entry;
		end
	end

	// ****************************************************************
	// Line framing
	// ****************************************************************
	line_wait_timer u_wait (
		.pclk(pclk),
		.presetn(presetn),
		.line_start(line_start),
		.wait_cycles(cfg.line_wait),
		.busy(wait_busy),
		.done(wait_done)
	);

	unit_byte_pacer u_pacer (
		.pclk(pclk),
		.presetn(presetn),
		.line_start(line_start),
		.unit_tick(unit_tick && state == FR_SEND),
		.whole_bytes(cfg.whole_bytes),
		.fraction_bytes(cfg.fraction_bytes),
		.unit_bytes(unit_bytes)
	);

	always_comb begin
		next_state = state;
		case (state)
			FR_IDLE: begin
				if (line_start) begin
					next_state = FR_WAIT;
				end
			end
			FR_WAIT: begin
				if (line_start) begin
					next_state = FR_WAIT;
				end else if (wait_done) begin
					next_state = FR_SEND;
				end
			end
			FR_SEND: begin
				if (line_start) begin
					next_state = FR_WAIT;
				end
			end
			default: begin
				next_state = FR_IDLE;
			end
		endcase
		next_data_enable = (next_state == FR_SEND);
		next_vblank_interlace = cfg.interlaced;
		next_attr_interlace = cfg.interlaced;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= FR_IDLE;
			data_enable <= 1'b0;
			vblank_interlace <= 1'b0;
			attr_interlace <= 1'b0;
		end else begin
			state <= next_state;
			data_enable <= next_data_enable;
			vblank_interlace <= next_vblank_interlace;
			attr_interlace <= next_attr_interlace;
		end
	end
endmodule // stream4_tu_framing_config

// ### test/framing_cfg_assertions.sv
// Concurrent checks on the ports of the stream-four framing bank.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ns
module framing_cfg_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Framing
	input wire logic line_start,
	input wire logic unit_tick,
	input wire stream4_cfg_pkg::framing_cfg_t cfg,
	input wire logic vblank_interlace,
	input wire logic attr_interlace,
	input wire logic data_enable,
	input wire logic [stream4_cfg_pkg::WHOLE_WIDTH:0] unit_bytes
);
	import stream4_cfg_pkg::*;
	// ***
	// Cycles since the last line start, with the wait it launched.
	// ***
	logic [7:0] since;
	logic [7:0] next_since;
	logic [6:0] held;
	logic [6:0] next_held;
	always_comb begin
		next_since = (since == 8'hFF) ? since : since + 8'h01;
		next_held = held;
		if (line_start) begin
			next_since = 8'h01;
			next_held = cfg.line_wait;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since <= 8'hFF;
			held <= 7'h00;
		end else begin
			since <= next_since;
			held <= next_held;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	access_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no answer after wait state");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
	error_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	interlace_copy_a: assert property (1 |=> {vblank_interlace, attr_interlace} == {2{$past(cfg.interlaced)}})
		else $error("interlace outputs do not follow the bit");
	unit_size_a: assert property (!cfg.unit_size[0] && cfg.unit_size >= UNIT_SIZE_MIN && cfg.unit_size <= UNIT_SIZE_MAX)
		else $error("unit size out of range");
	wait_start_a: assert property (line_start |=> !data_enable) else $error("data on a new line too soon");
	wait_length_a: assert property ($rose(data_enable) |-> since == {1'b0, held} + 8'h02)
		else $error("initial wait length wrong");
	enable_holds_a: assert property (data_enable && !line_start |=> data_enable) else $error("send phase dropped");
	unit_range_a: assert property (unit_tick && data_enable |=> unit_bytes == {1'b0, cfg.whole_bytes}
		|| unit_bytes == {1'b0, cfg.whole_bytes} + 9'h001) else $error("unit bytes out of range");
	whole_only_a: assert property (unit_tick && data_enable && cfg.fraction_bytes == 10'h000
		|=> unit_bytes == {1'b0, cfg.whole_bytes}) else $error("extra byte without fraction");
endmodule // framing_cfg_checker
bind stream4_tu_framing_config framing_cfg_checker chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
	.line_start, .unit_tick, .cfg, .vblank_interlace, .attr_interlace, .data_enable, .unit_bytes);

// ### test/framing_sink_model.sv
// Link-side pacer: starts lines, ticks units and sums the bytes granted.
// Assumes start is a one-cycle pulse on pclk.
`timescale 1ns/1ns
module framing_sink_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench control
	input wire logic start,
	input wire logic [3:0] ticks,
	output logic busy,
	output logic [7:0] wait_seen,
	output logic [11:0] byte_sum,
	// Bank side
	input wire logic data_enable,
	input wire logic [stream4_cfg_pkg::WHOLE_WIDTH:0] unit_bytes,
	output logic line_start,
	output logic unit_tick
);
	logic [1:0] phase;
	logic [3:0] left;
	logic pend;
	assign busy = phase != 2'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{phase, left, pend, line_start, unit_tick, wait_seen, byte_sum} <= '0;
		end else begin
			line_start <= start;
			pend <= unit_tick;
			if (start) begin
				phase <= 2'h1;
				wait_seen <= 8'h00;
				byte_sum <= 12'h000;
				left <= ticks;
			end else if (phase == 2'h1) begin
				wait_seen <= wait_seen + 8'h01;
				// The previous line may still be sending when line_start is seen.
				if (data_enable && !line_start) phase <= 2'h2;
			end else if (phase == 2'h2) begin
				unit_tick <= !unit_tick && left != 4'h0;
				left <= left - {3'h0, unit_tick};
				if (pend) byte_sum <= byte_sum + {3'h0, unit_bytes};
				if (left == 4'h0 && !unit_tick && !pend) phase <= 2'h0;
			end
		end
	end
endmodule // framing_sink_model

// ### test/tb.sv
// Self-checking bench for the stream-four framing configuration bank.
// Assumes an APB slave with one wait state and the sink model on the framing side.
`timescale 1ns/1ns
module tb;
	import stream4_cfg_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [5:0] slot_index = 6'h00;
	logic start = 1'b0;
	logic [3:0] ticks = 4'h4;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, busy, line_start, unit_tick, data_enable, vblank_interlace, attr_interlace;
	framing_cfg_t cfg;
	logic [15:0] words_per_lane;
	logic [8:0] unit_bytes;
	logic [7:0] slot_entry, wait_seen;
	logic [11:0] byte_sum;
	logic [15:0] usz [4] = '{16'h2120, 16'h1420, 16'h7F40, 16'h3232};
	// Four lines over three colour formats, the first two both format 2; the third also covers a zero wait and a carrying fraction.
	logic [7:0] whole_set [4] = '{8'h04, 8'h0A, 8'h40, 8'h30};
	logic [9:0] frac_set [4] = '{10'h000, 10'h1F4, 10'h2EE, 10'h000};
	int fmt_set [4] = '{2, 2, 0, 1};
	logic [31:0] exp_wait [4] = '{32'h43, 32'h15, 32'h03, 32'h0B};
	logic [31:0] exp_sum [4] = '{32'h10, 32'h2A, 32'h103, 32'hC0};
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	always #5 pclk = ~pclk;
	stream4_tu_framing_config dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .line_start, .unit_tick, .slot_index, .cfg, .words_per_lane, .vblank_interlace,
		.attr_interlace, .data_enable, .unit_bytes, .slot_entry);
	framing_sink_model sink (.pclk, .presetn, .start, .ticks, .busy, .wait_seen, .byte_sum, .data_enable,
		.unit_bytes, .line_start, .unit_tick);
	task automatic summarize();
		$display("checks=%0d fails=%0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rd, exp);
		cmp({31'h0, err}, 32'h0);
	endtask
	function automatic logic [15:0] lane_words(input int words, input int lanes);
		return 16'((words % lanes == 0) ? words - lanes : words + words % lanes - lanes);
	endfunction
	function automatic logic [6:0] init_wait(input int mb, input int fmt);
		return 7'(mb <= 4 ? 64 : fmt == 0 ? 64 - mb : fmt == 1 ? (64 - mb) / 2 : (64 - mb) / 3);
	endfunction
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(ADDR_UNIT_SIZE, 32'h40);
		rdchk(ADDR_LINE_WAIT, 32'h40);
		rdchk(ADDR_WHOLE_BYTES, 32'h0);
		rdchk(ADDR_FRACTION_BYTES, 32'h0);
		rdchk(ADDR_INTERLACE, 32'h0);
		foreach (usz[i]) begin
			wr(ADDR_UNIT_SIZE, {24'h0, usz[i][15:8]});
			rdchk(ADDR_UNIT_SIZE, {24'h0, usz[i][7:0]});
		end
		wr(ADDR_UNIT_SIZE, 32'h40);
		for (int l = 1; l <= 4; l = l * 2) begin
			wr(ADDR_WORDS_PER_LANE, {16'h0, lane_words((1366 * 24 + 15) / 16, l)});
			cmp({16'h0, words_per_lane}, (l == 4) ? 32'h7FE : 32'h800);
		end
		wr(ADDR_INTERLACE, 32'hFFFFFFFF);
		rdchk(ADDR_INTERLACE, 32'h1);
		cmp({30'h0, vblank_interlace, attr_interlace}, 32'h3);
		wr(ADDR_FRACTION_BYTES, 32'hFFFFF3E7);
		rdchk(ADDR_FRACTION_BYTES, 32'h3E7);
		pstrb <= 4'hE;
		wr(ADDR_WHOLE_BYTES, 32'h55);
		pstrb <= 4'hF;
		rdchk(ADDR_WHOLE_BYTES, 32'h0);
		wr(ADDR_TABLE_BASE, 32'hFFFFFF5A);
		wr(ADDR_TABLE_LAST - 12'h003, 32'hC3);
		rdchk(ADDR_TABLE_BASE, 32'h0);
		slot_index <= 6'h3F;
		repeat (2) @(posedge pclk);
		cmp({24'h0, slot_entry}, 32'hC3);
		slot_index <= 6'h00;
		repeat (2) @(posedge pclk);
		cmp({24'h0, slot_entry}, 32'h5A);
		apb(1'b0, 12'h400, 32'h0);
		cmp({31'h0, err}, 32'h1);
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_WHOLE_BYTES, {24'h0, whole_set[k]});
			wr(ADDR_FRACTION_BYTES, {22'h0, frac_set[k]});
			wr(ADDR_LINE_WAIT, {25'h0, init_wait(int'(whole_set[k]), fmt_set[k])});
			start <= 1'b1;
			@(posedge pclk);
			start <= 1'b0;
			do @(posedge pclk); while (busy !== 1'b0);
			cmp({24'h0, wait_seen}, exp_wait[k]);
			cmp({20'h0, byte_sum}, exp_sum[k]);
		end
		cmp({cfg.unit_size, cfg.whole_bytes, cfg.fraction_bytes, cfg.line_wait}, {7'h40, 8'h30, 10'h000, 7'h08});
		rdchk(ADDR_STATUS, 32'h182);
		summarize();
	end
endmodule // tb
